// *** clg_defines.vh ***
// Register map, field positions and timing constants of the logic gate block
`ifndef CLG_DEFINES_VH
`define CLG_DEFINES_VH
// Register word addresses (byte offsets)
`define CLG_ADDR_CTRL 8'h00
`define CLG_ADDR_STAT 8'h04
`define CLG_GRP_CFG 4'h1
`define CLG_GRP_SRC 4'h2
`define CLG_GRP_VAL 4'h3
`define CLG_GRP_TIM 4'h4
// Gate configuration word fields
`define CLG_CFG_FUNC 1:0
`define CLG_CFG_NIN 3:2
`define CLG_CFG_INV 7:4
`define CLG_CFG_INT 11:8
`define CLG_CFG_INT_LSB 8
`define CLG_CFG_BYTE 12
`define CLG_CFG_OINV 13
`define CLG_CFG_ONCHG 14
// Value word fields
`define CLG_VAL_LO 7:0
`define CLG_VAL_HI 15:8
// Delay word fields, in timebase ticks
`define CLG_TIM_ON 7:0
`define CLG_TIM_OFF 15:8
`define CLG_TIM_CYC 23:16
// Combining functions
`define CLG_F_AND 2'h0
`define CLG_F_OR 2'h1
`define CLG_F_XOR 2'h2
`define CLG_F_ANDFB 2'h3
// Reset values
`define CLG_RST_CTRL 32'h0000_0000
`define CLG_RST_CFG 32'h0000_0000
`define CLG_RST_SRC 32'h0000_0000
`define CLG_RST_VAL 32'h0000_FF00
`define CLG_RST_TIM 32'h0000_0000
// Number of internal one-bit sources besides the gate outputs
`define CLG_NINT 8
// Timebase
`define CLG_CLK_KHZ 125000
`define CLG_TICK_MS 100
`define CLG_TICK_CYC (`CLG_TICK_MS * `CLG_CLK_KHZ)
`endif

// *** clg_timer.v ***
// Retriggerable down counter on the delay timebase
`default_nettype none
module clg_timer (
	input wire clk_sys,
	input wire rst_n,
	input wire tick,
	input wire load,
	input wire [7:0] len,
	output wire busy,
	output reg done_r
);
	reg [7:0] cnt_r;

	assign busy = (cnt_r != 8'h00);

	// Load always wins so that a retrigger restarts from the full length
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= 8'h00;
			done_r <= 1'b0;
		end else begin
			done_r <= 1'b0;
			if (load) begin
				cnt_r <= len;
			end else if (tick && busy) begin
				cnt_r <= cnt_r - 8'h01;
				done_r <= (cnt_r == 8'h01);
			end
		end
	end
endmodule // clg_timer
`default_nettype wire

// *** clg_gates.v ***
// Four configurable logic gates with delays, send criteria and APB registers
//
// Notes on behaviour
// - Up to four gates, count set by software
// - Each gate uses one to four inputs
// - Function AND, OR, XOR or AND with feedback
// - Every input may be inverted before combining
// - Output is bit or byte; bit may invert
// - Input from telegram or selected internal bit
// - Evaluate only when a new input arrives
// - Feedback mode: output fed back into input 1
// - Other input at 0 clears output and input 1
// - Send on every input event or on change
// - Each received 1 restarts the switch-on delay
// - Each 0 result restarts the switch-off delay
// - Evaluate and send only after delay expires
// - Optional cyclic resend of each gate output
// - Logic 0 and 1 mapped to configured values
// - Gate output may feed its own inputs safely
//
// Added by the designer: the register offsets and the APB slave port.
`include "clg_defines.vh"
`default_nettype none
module clg_gates #(
	parameter [23:0] TICK_CYC = `CLG_TICK_CYC
) (
	input wire clk_sys,
	input wire rst_n,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata_r,
	output reg pready_r,
	output reg pslverr_r,
	input wire tel_in_valid,
	input wire [1:0] tel_in_gate,
	input wire [1:0] tel_in_idx,
	input wire tel_in_val,
	input wire [7:0] int_bits,
	output reg tx_valid_r,
	output reg [1:0] tx_gate_r,
	output reg tx_byte_r,
	output reg [7:0] tx_data_r
);
	reg [2:0] gate_count_setting;
	reg [31:0] cfg_r [0:3];
	reg [31:0] src_r [0:3];
	reg [31:0] val_r [0:3];
	reg [31:0] tim_r [0:3];
	reg [23:0] tick_cnt_r;
	reg tick_r;
	reg [11:0] src_q_r;
	reg [3:0] pend_r;
	wire [3:0] out_all;
	wire [3:0] obit;
	wire [15:0] in_all;
	wire [3:0] sreq;
	wire [11:0] src_now;
	reg [3:0] grant;
	reg [31:0] rd_val;
	reg hit;
	integer k;
	integer m;

	// Pick one bit of the internal source vector; unused codes read as 0
	function clg_pick;
		input [11:0] v;
		input [3:0] sel;
		begin
			clg_pick = (sel < 4'hc) ? v[sel] : 1'b0;
		end
	endfunction

	// Combine the effective inputs; unused inputs are neutral
	function clg_eval;
		input [1:0] func;
		input [3:0] eff;
		input [3:0] used;
		begin
			case (func)
				`CLG_F_OR: clg_eval = |(eff & used);
				`CLG_F_XOR: clg_eval = ^(eff & used);
				default: clg_eval = &(eff | ~used);
			endcase
		end
	endfunction

	// Map a logic level to the configured bit or byte value
	function [7:0] clg_map;
		input lvl;
		input [31:0] val;
		input [31:0] cfg;
		reg [7:0] v;
		begin
			v = lvl ? val[`CLG_VAL_HI] : val[`CLG_VAL_LO];
			if (cfg[`CLG_CFG_BYTE]) begin
				clg_map = v;
			end else begin
				clg_map = {7'h00, v[0] ^ cfg[`CLG_CFG_OINV]};
			end
		end
	endfunction

	// Gate outputs join the internal bits, so feedback loops pass a register stage
	assign src_now = {obit, int_bits};

	// Delay timebase; long, so a parameter lets simulation shorten it
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt_r <= 24'h00_0000;
			tick_r <= 1'b0;
			src_q_r <= 12'h000;
		end else begin
			tick_r <= (tick_cnt_r == TICK_CYC - 24'h00_0001);
			if (tick_cnt_r == TICK_CYC - 24'h00_0001) begin
				tick_cnt_r <= 24'h00_0000;
			end else begin
				tick_cnt_r <= tick_cnt_r + 24'h00_0001;
			end
			src_q_r <= src_now;
		end
	end

	genvar g;
	genvar j;
	generate
		for (g = 0; g < 4; g = g + 1) begin : gate
			localparam [2:0] GI = g;
			wire [31:0] cf = cfg_r[g];
			wire [31:0] tm = tim_r[g];
			wire act = (GI < gate_count_setting);
			wire [3:0] used;
			wire [3:0] ev;
			wire [3:0] nv;
			wire [3:0] in_nxt;
			reg [3:0] in_r;
			reg out_r;
			wire on_busy;
			wire on_done;
			wire off_busy;
			wire off_done;
			wire cyc_busy;
			wire cyc_done;
			wire any_ev = |ev;
			wire on_trig = |(ev & nv) && (tm[`CLG_TIM_ON] != 8'h00);
			wire eval_now = any_ev && !on_trig && !on_busy;
			wire do_eval = eval_now | on_done | off_done;
			wire from_off = off_done & !eval_now & !on_done;
			wire res = clg_eval(cf[`CLG_CFG_FUNC], in_nxt ^ cf[`CLG_CFG_INV], used);
			wire hold0 = !res && (tm[`CLG_TIM_OFF] != 8'h00) && !from_off;
			wire commit = do_eval && !hold0;

			// Inputs beyond the configured count are ignored
			assign used = (cf[`CLG_CFG_NIN] == 2'h0) ? 4'h1 :
				(cf[`CLG_CFG_NIN] == 2'h1) ? 4'h3 :
				(cf[`CLG_CFG_NIN] == 2'h2) ? 4'h7 : 4'hf;

			for (j = 0; j < 4; j = j + 1) begin : inp
				wire isint = cf[`CLG_CFG_INT_LSB + j];
				wire [3:0] sel = src_r[g][j * 4 +: 4];
				wire ichg = clg_pick(src_now, sel) != clg_pick(src_q_r, sel);
				wire xhit = tel_in_valid && (tel_in_gate == GI[1:0]) &&
					(tel_in_idx == j);
				// A changed internal bit counts as a new value
				assign ev[j] = act && used[j] && (isint ? ichg : xhit);
				assign nv[j] = isint ? clg_pick(src_now, sel) : tel_in_val;
				assign in_nxt[j] = ev[j] ? nv[j] : in_r[j];
			end

			// Every received 1 restarts the switch-on delay
			clg_timer u_on (
				.clk_sys(clk_sys),
				.rst_n(rst_n),
				.tick(tick_r),
				.load(on_trig),
				.len(tm[`CLG_TIM_ON]),
				.busy(on_busy),
				.done_r(on_done)
			);

			// A 0 result restarts the off delay; a 1 cancels it
			clg_timer u_off (
				.clk_sys(clk_sys),
				.rst_n(rst_n),
				.tick(tick_r),
				.load((do_eval && hold0) || (commit && off_busy)),
				.len(hold0 ? tm[`CLG_TIM_OFF] : 8'h00),
				.busy(off_busy),
				.done_r(off_done)
			);

			// Cyclic resend, free running while a period is set
			clg_timer u_cyc (
				.clk_sys(clk_sys),
				.rst_n(rst_n),
				.tick(tick_r),
				.load(cyc_done || (!cyc_busy && act && tm[`CLG_TIM_CYC] != 8'h00)),
				.len(act ? tm[`CLG_TIM_CYC] : 8'h00),
				.busy(cyc_busy),
				.done_r(cyc_done)
			);

			// Input store and output commit
			always @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n) begin
					in_r <= 4'h0;
					out_r <= 1'b0;
				end else begin
					in_r <= in_nxt;
					if (commit) begin
						out_r <= res;
						if (cf[`CLG_CFG_FUNC] == `CLG_F_ANDFB && !res) begin
							in_r[0] <= 1'b0;
						end
					end
				end
			end

			// Send on every committed result, or only when the value moves
			assign sreq[g] = act && ((commit && (!cf[`CLG_CFG_ONCHG] ||
				res != out_r)) || cyc_done);
			assign out_all[g] = out_r;
			assign obit[g] = (out_r ? val_r[g][8] : val_r[g][0]) ^ cf[`CLG_CFG_OINV];
			assign in_all[g * 4 +: 4] = in_r;
		end
	endgenerate

	// Lowest pending gate is sent first; the others follow, one per cycle
	always @* begin
		grant = 4'h0;
		if (pend_r[0]) begin
			grant = 4'h1;
		end else if (pend_r[1]) begin
			grant = 4'h2;
		end else if (pend_r[2]) begin
			grant = 4'h4;
		end else if (pend_r[3]) begin
			grant = 4'h8;
		end
	end

	// Telegram output; a new request in the grant cycle stays pending
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pend_r <= 4'h0;
			tx_valid_r <= 1'b0;
			tx_gate_r <= 2'h0;
			tx_byte_r <= 1'b0;
			tx_data_r <= 8'h00;
		end else begin
			pend_r <= (pend_r & ~grant) | sreq;
			tx_valid_r <= |grant;
			for (k = 0; k < 4; k = k + 1) begin
				if (grant[k]) begin
					tx_gate_r <= k[1:0];
					tx_byte_r <= cfg_r[k][`CLG_CFG_BYTE];
					tx_data_r <= clg_map(out_all[k], val_r[k], cfg_r[k]);
				end
			end
		end
	end

	// Read decode; word address by group and gate index
	always @* begin
		hit = 1'b1;
		rd_val = 32'h0000_0000;
		if (paddr == `CLG_ADDR_CTRL) begin
			rd_val = {29'h0000_0000, gate_count_setting};
		end else if (paddr == `CLG_ADDR_STAT) begin
			rd_val = {12'h000, in_all, out_all};
		end else if (paddr[1:0] != 2'h0) begin
			hit = 1'b0;
		end else begin
			case (paddr[7:4])
				`CLG_GRP_CFG: rd_val = cfg_r[paddr[3:2]];
				`CLG_GRP_SRC: rd_val = src_r[paddr[3:2]];
				`CLG_GRP_VAL: rd_val = val_r[paddr[3:2]];
				`CLG_GRP_TIM: rd_val = tim_r[paddr[3:2]];
				default: hit = 1'b0;
			endcase
		end
	end

	// APB slave: answer in the first access cycle; writes land there too
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
			gate_count_setting <= 3'h0;
			for (m = 0; m < 4; m = m + 1) begin
				cfg_r[m] <= `CLG_RST_CFG;
				src_r[m] <= `CLG_RST_SRC;
				val_r[m] <= `CLG_RST_VAL;
				tim_r[m] <= `CLG_RST_TIM;
			end
		end else begin
			pready_r <= psel && !penable;
			pslverr_r <= psel && !penable && !hit;
			if (psel && !penable) begin
				prdata_r <= pwrite ? 32'h0000_0000 : rd_val;
			end
			if (psel && penable && pready_r && pwrite && hit) begin
				if (paddr == `CLG_ADDR_CTRL) begin
					// Values 5 to 7 in bits 2:0 are clipped to four gates
					gate_count_setting <= (pwdata[2:0] > 3'h4) ? 3'h4 : pwdata[2:0];
				end
				case (paddr[7:4])
					`CLG_GRP_CFG: cfg_r[paddr[3:2]] <= {17'h0_0000, pwdata[14:0]};
					`CLG_GRP_SRC: src_r[paddr[3:2]] <= {16'h0000, pwdata[15:0]};
					`CLG_GRP_VAL: val_r[paddr[3:2]] <= {16'h0000, pwdata[15:0]};
					`CLG_GRP_TIM: tim_r[paddr[3:2]] <= {8'h00, pwdata[23:0]};
					default: ;
				endcase
			end
		end
	end
endmodule // clg_gates
`default_nettype wire

// *** clg_gates_sva.sv ***
// Port checker of the logic gate block
`default_nettype none
module clg_gates_sva (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata_r,
	input wire logic pready_r,
	input wire logic pslverr_r,
	input wire logic tx_valid_r,
	input wire logic tx_byte_r,
	input wire logic [7:0] tx_data_r
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// Bus steps shared by the properties
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_answer;
		pready_r ##1 !pready_r;
	endsequence
	property p_ready;
		s_setup |=> s_answer;
	endproperty
	a_ready: assert property (p_ready) else $error("ready not a single pulse");
	property p_ready_cause;
		pready_r |-> $past(psel && !penable);
	endproperty
	a_ready_cause: assert property (p_ready_cause) else $error("ready without setup");
	property p_err_pair;
		pslverr_r |-> pready_r;
	endproperty
	a_err_pair: assert property (p_err_pair) else $error("error without ready");
	property p_unaligned;
		s_setup and (paddr[1:0] != 2'h0) |=> pslverr_r;
	endproperty
	a_unaligned: assert property (p_unaligned) else $error("unaligned accepted");
	property p_unmapped;
		s_setup and (paddr == 8'h08) |=> pslverr_r;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped accepted");
	property p_wr_zero;
		pready_r && pwrite |-> prdata_r == 32'h0000_0000;
	endproperty
	a_wr_zero: assert property (p_wr_zero) else $error("write returned data");
	// No gate is active until software sets the count, so nothing may be sent in the first three cycles after reset
	property p_rst_quiet;
		$rose(rst_n) |-> !tx_valid_r [*3];
	endproperty
	a_rst_quiet: assert property (p_rst_quiet) else $error("send right after reset");
	property p_bit_fmt;
		tx_valid_r && !tx_byte_r |-> tx_data_r[7:1] == 7'h00;
	endproperty
	a_bit_fmt: assert property (p_bit_fmt) else $error("bit object not one bit");
endmodule // clg_gates_sva
bind clg_gates clg_gates_sva i_sva (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata_r(prdata_r),
	.pready_r(pready_r), .pslverr_r(pslverr_r), .tx_valid_r(tx_valid_r),
	.tx_byte_r(tx_byte_r), .tx_data_r(tx_data_r));
`default_nettype wire

// *** clg_peer.sv ***
// Bus peer that receives the output telegrams of the gates
`default_nettype none
module clg_peer (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic tx_valid_r,
	input wire logic [1:0] tx_gate_r,
	input wire logic [7:0] tx_data_r,
	output var logic [15:0] rx_cnt,
	output var logic [9:0] rx_last
);
	timeunit 1ns;
	timeprecision 1ps;
	// Telegram stands one cycle only, so it is taken whole at that edge
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rx_cnt <= 16'h0000;
			rx_last <= 10'h000;
		end else if (tx_valid_r) begin
			rx_cnt <= rx_cnt + 16'h0001;
			rx_last <= {tx_gate_r, tx_data_r};
		end
	end
endmodule // clg_peer
`default_nettype wire

// *** clg_gates_tb_top.sv ***
// Self-checking bench of the logic gate block
`include "clg_defines.vh"
`default_nettype none
module clg_gates_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic tel_in_valid = 1'b0;
	logic [1:0] tel_in_gate = 2'h0;
	logic [1:0] tel_in_idx = 2'h0;
	logic tel_in_val = 1'b0;
	logic [7:0] int_bits = 8'h00;
	logic [31:0] prdata_r;
	logic pready_r;
	logic pslverr_r;
	logic tx_valid_r;
	logic [1:0] tx_gate_r;
	logic tx_byte_r;
	logic [7:0] tx_data_r;
	logic [15:0] rx_cnt;
	logic [9:0] rx_last;
	logic [31:0] rnd = 32'h0000_f433;
	logic [31:0] rd;
	logic err;
	logic [1:0] g;
	logic [1:0] i;
	int fails = 0;
	int cmp_count = 0;
	int wait_max = 12;
	int lat = 0;
	logic [15:0] c1;
	logic [7:0] e_int;
	logic byte_seen = 1'b0;
	logic [3:0] in_v [4] = '{4'h0, 4'h0, 4'h0, 4'h0};
	// Gates: OR bit, AND inverted bit, XOR of three with one inverted byte, feedback byte
	logic [31:0] cfg [4] = '{32'h0000_0005, 32'h0000_2004, 32'h0000_102A, 32'h0000_1007};
	logic [31:0] vw [4] = '{32'h0000_FF00, 32'h0000_FF00, 32'h0000_C33C, 32'h0000_A511};

	clg_gates #(.TICK_CYC(24'h00_0004)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata_r(prdata_r), .pready_r(pready_r), .pslverr_r(pslverr_r),
		.tel_in_valid(tel_in_valid), .tel_in_gate(tel_in_gate), .tel_in_idx(tel_in_idx),
		.tel_in_val(tel_in_val), .int_bits(int_bits), .tx_valid_r(tx_valid_r),
		.tx_gate_r(tx_gate_r), .tx_byte_r(tx_byte_r), .tx_data_r(tx_data_r));
	clg_peer i_peer (.clk_sys(clk_sys), .rst_n(rst_n), .tx_valid_r(tx_valid_r),
		.tx_gate_r(tx_gate_r), .tx_data_r(tx_data_r), .rx_cnt(rx_cnt), .rx_last(rx_last));

	// Free-running 125 MHz clock
	always #4 clk_sys = ~clk_sys;

	// Object size of the last telegram; the peer keeps only gate and data
	always @(posedge clk_sys) begin
		if (tx_valid_r) begin
			byte_seen <= tx_byte_r;
		end
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction

	// Expected output after a new input; feedback mode clears input 1 on a 0 result
	function automatic logic [7:0] expect_tx(input logic [1:0] gi);
		logic [3:0] used;
		logic [3:0] eff;
		logic r;
		used = 4'hF >> (2'h3 - cfg[gi][`CLG_CFG_NIN]);
		eff = (in_v[gi] ^ cfg[gi][`CLG_CFG_INV]) & used;
		case (cfg[gi][`CLG_CFG_FUNC])
			`CLG_F_OR: r = |eff;
			`CLG_F_XOR: r = ^eff;
			default: r = (eff == used);
		endcase
		if (cfg[gi][`CLG_CFG_FUNC] == `CLG_F_ANDFB && !r) in_v[gi][0] = 1'b0;
		if (cfg[gi][`CLG_CFG_BYTE]) return r ? vw[gi][15:8] : vw[gi][7:0];
		return {7'h00, (r ? vw[gi][8] : vw[gi][0]) ^ cfg[gi][`CLG_CFG_OINV]};
	endfunction

	task automatic tally_and_finish(input logic hung);
		if (hung) fails++;
		if (fails == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic check(input logic ok, input string msg);
		cmp_count++;
		if (ok !== 1'b1) begin
			fails++;
			$display("FAIL %0t %s", $time, msg);
		end
	endtask

	// One transfer; request held until ready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready_r !== 1'b1 && n < 20);
		rd = prdata_r;
		err = pslverr_r;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready_r !== 1'b1) tally_and_finish(1'b1);
	endtask

	// Sends one input telegram and checks whether and what the gate answers
	task automatic tel(input logic [1:0] gi, input logic [1:0] ii, input logic v,
		input logic exp);
		logic [15:0] c0;
		logic [7:0] e;
		int n;
		c0 = rx_cnt;
		e = 8'h00;
		if (exp) begin
			in_v[gi][ii] = v;
			e = expect_tx(gi);
		end
		@(posedge clk_sys);
		tel_in_valid <= 1'b1;
		tel_in_gate <= gi;
		tel_in_idx <= ii;
		tel_in_val <= v;
		@(posedge clk_sys);
		tel_in_valid <= 1'b0;
		n = 0;
		while (rx_cnt === c0 && n < wait_max) begin
			@(posedge clk_sys);
			n++;
		end
		lat = n;
		check((rx_cnt !== c0) === exp, "telegram count");
		if (exp) check(rx_last === {gi, e}, "output telegram");
		if (exp) check(byte_seen === cfg[gi][`CLG_CFG_BYTE], "object size");
	endtask

	initial begin
		repeat (16) @(posedge clk_sys);
		rst_n <= 1'b1;
		apb(1'b0, 8'h04, 32'h0000_0000);
		check(rd === 32'h0000_0000, "status after reset");
		apb(1'b0, 8'h30, 32'h0000_0000);
		check(rd === `CLG_RST_VAL, "value reset");
		apb(1'b0, 8'h08, 32'h0000_0000);
		check(err === 1'b1, "unmapped read");
		apb(1'b0, 8'h11, 32'h0000_0000);
		check(err === 1'b1, "unaligned read");
		for (int k = 0; k < 4; k++) begin
			apb(1'b1, 8'h10 + 8'(4 * k), cfg[k]);
			apb(1'b1, 8'h30 + 8'(4 * k), vw[k]);
		end
		apb(1'b1, `CLG_ADDR_CTRL, 32'h0000_0002);
		tel(2'h3, 2'h0, 1'b1, 1'b0);
		apb(1'b1, `CLG_ADDR_CTRL, 32'h0000_0004);
		// Feedback: input 1 set last gives 1; input 2 dropping clears input 1
		tel(2'h3, 2'h1, 1'b1, 1'b1);
		tel(2'h3, 2'h0, 1'b1, 1'b1);
		tel(2'h3, 2'h1, 1'b0, 1'b1);
		tel(2'h3, 2'h1, 1'b1, 1'b1);
		repeat (80) begin
			rnd = xs(rnd);
			int_bits <= rnd[15:8];
			g = rnd[1:0];
			i = rnd[3:2];
			if (i > cfg[g][`CLG_CFG_NIN]) i = 2'h0;
			tel(g, i, rnd[4], 1'b1);
		end
		// Internal source: gate 1 input 1 follows internal bit 2
		int_bits <= 8'h00;
		apb(1'b1, 8'h24, 32'h0000_0002);
		cfg[1] = 32'h0000_2104;
		apb(1'b1, 8'h14, cfg[1]);
		in_v[1][0] = 1'b1;
		e_int = expect_tx(2'h1);
		c1 = rx_cnt;
		@(posedge clk_sys);
		int_bits <= 8'h04;
		repeat (6) @(posedge clk_sys);
		check(rx_cnt === c1 + 16'h0001 && rx_last === {2'h1, e_int}, "internal input");
		// Send on change only: a repeated value stays silent
		tel(2'h0, 2'h0, 1'b0, 1'b1);
		tel(2'h0, 2'h1, 1'b0, 1'b1);
		cfg[0] = 32'h0000_4005;
		apb(1'b1, 8'h10, cfg[0]);
		tel(2'h0, 2'h1, 1'b0, 1'b0);
		tel(2'h0, 2'h0, 1'b1, 1'b1);
		// Switch-on delay: a second 1 restarts it, so only one late telegram follows
		cfg[0] = 32'h0000_0005;
		apb(1'b1, 8'h10, cfg[0]);
		tel(2'h0, 2'h0, 1'b0, 1'b1);
		tel(2'h0, 2'h1, 1'b0, 1'b1);
		apb(1'b1, 8'h40, 32'h0000_0002);
		c1 = rx_cnt;
		in_v[0][0] = 1'b1;
		wait_max = 3;
		tel(2'h0, 2'h0, 1'b1, 1'b0);
		wait_max = 40;
		tel(2'h0, 2'h1, 1'b1, 1'b1);
		check(rx_cnt === c1 + 16'h0001 && lat > 4, "retriggered on delay");
		// Cyclic resend every three ticks; on delay kept shorter than the period
		c1 = rx_cnt;
		apb(1'b1, 8'h40, 32'h0003_0002);
		repeat (40) @(posedge clk_sys);
		check(rx_cnt >= c1 + 16'h0002 && rx_last === {2'h0, 8'h01}, "cyclic resend");
		apb(1'b1, 8'h40, 32'h0000_0000);
		tally_and_finish(1'b0);
	end
endmodule // clg_gates_tb_top
`default_nettype wire
